/* File: src/monitor_status_pkg.sv */
// Package with register map, field layout and bus constants of the monitor status bank.
package monitor_status_pkg;

   // Bus and register widths.
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int REG_W  = 8;

   // Register indices as printed; the byte address is four times the index.
   localparam logic [ADDR_W-1:0] MON_STATUS_IDX  = 8'h03;
   localparam logic [ADDR_W-1:0] SI_VERSION_IDX  = 8'h05;
   localparam logic [ADDR_W-1:0] MON_CONTROL_IDX = 8'h06;

   // Byte addresses derived from the indices.
   localparam logic [ADDR_W-1:0] MON_STATUS_ADDR  = ADDR_W'(MON_STATUS_IDX * 4);
   localparam logic [ADDR_W-1:0] SI_VERSION_ADDR  = ADDR_W'(SI_VERSION_IDX * 4);
   localparam logic [ADDR_W-1:0] MON_CONTROL_ADDR = ADDR_W'(MON_CONTROL_IDX * 4);

   // Bit positions inside the monitor status register.
   localparam int RESERVED_BIT   = 7;
   localparam int AUX_REG_BIT    = 6;
   localparam int SECOND_CONV_BIT = 5;
   localparam int NET_SUPPLY_BIT = 4;
   localparam int FILT_SUPPLY_BIT = 3;
   localparam int OSC_RUN_BIT    = 2;
   localparam int THERM_WARN_BIT = 1;
   localparam int PRIOR_TSD_BIT  = 0;

   // Field layout of the silicon version register.
   localparam int REVISION_LSB = 5;
   localparam int REVISION_W   = 3;
   localparam int PART_ID_LSB  = 0;
   localparam int PART_ID_W    = 5;

   // Control register bit that clears the remembered shutdown flag.
   localparam int CLEAR_TSD_BIT = 0;

   // Reset values.
   localparam logic [REG_W-1:0] MON_STATUS_RESET = 8'h00;
   localparam logic [DATA_W-1:0] RDATA_RESET     = 32'h0000_0000;

   // Write strobe width.
   localparam int STRB_W = DATA_W / 8;

   // Response codes.
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : monitor_status_pkg

/* File: src/monitor_status_regs.sv */
// Read-only monitor status and silicon version registers behind an AXI4-Lite slave.
`timescale 1ns/1ps

// Function
// - Regulator bit high while above undervoltage.
// - Converter bit high while above undervoltage.
// - Network supply bit high while above undervoltage.
// - Filtered supply bit high while above undervoltage.
// - Oscillator bit high only while crystal runs.
// - Thermal warning bit follows warning condition.
// - Remember a previous thermal shutdown event.
// - Status bit seven reserved, reads zero.
// - Read-only identification register at index five.
// - Revision in top three, part code below.
// - Status register at index three, read-only.
// - Status bits ordered six to zero, reset zero.
module monitor_status_regs #(
   parameter logic [monitor_status_pkg::REVISION_W-1:0] REVISION_CODE = 3'h0,
   parameter logic [monitor_status_pkg::PART_ID_W-1:0]  PART_ID_CODE  = 5'h12  // Value is arbitrary.
) (
   input  wire logic                                  clk,
   input  wire logic                                  reset_n,
   // Monitor levels from the analog comparators, synchronous to clk.
   input  wire logic                                  aux_regulator_ok,
   input  wire logic                                  second_converter_ok,
   input  wire logic                                  network_supply_ok,
   input  wire logic                                  filtered_supply_ok,
   input  wire logic                                  oscillator_running,
   input  wire logic                                  thermal_warning,
   input  wire logic                                  thermal_shutdown_event,
   // AXI4-Lite write address channel.
   input  wire logic [monitor_status_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]                            s_axi_awprot,
   input  wire logic                                  s_axi_awvalid,
   output logic                                       s_axi_awready,
   // AXI4-Lite write data channel.
   input  wire logic [monitor_status_pkg::DATA_W-1:0] s_axi_wdata,
   input  wire logic [monitor_status_pkg::STRB_W-1:0] s_axi_wstrb,
   input  wire logic                                  s_axi_wvalid,
   output logic                                       s_axi_wready,
   // AXI4-Lite write response channel.
   output logic [1:0]                                 s_axi_bresp,
   output logic                                       s_axi_bvalid,
   input  wire logic                                  s_axi_bready,
   // AXI4-Lite read address channel.
   input  wire logic [monitor_status_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]                            s_axi_arprot,
   input  wire logic                                  s_axi_arvalid,
   output logic                                       s_axi_arready,
   // AXI4-Lite read data channel.
   output logic [monitor_status_pkg::DATA_W-1:0]      s_axi_rdata,
   output logic [1:0]                                 s_axi_rresp,
   output logic                                       s_axi_rvalid,
   input  wire logic                                  s_axi_rready
);
   import monitor_status_pkg::*;

   // Overview of the bank.
   // The bank holds two registers that the host may only read: the monitor status word
   // and the silicon version word. A third address, the control word, has no storage of
   // its own; a write with bit zero set only clears the remembered shutdown flag.
   // Every monitor input is a level that the analog side keeps synchronous to clk, so the
   // status word is one flip-flop stage behind its inputs (bit zero two, through the shutdown flag) and needs no synchroniser.
   // The shutdown input may be a single-cycle pulse, so it is caught in a flag of its own
   // that stays set until software clears it; this is what lets a host learn of a
   // shutdown that ended before it could look.
   // The version word is fixed at build time through the two parameters. The revision
   // field has no defined reset value in silicon, so it is simply whatever the parameter
   // says; the part code is what host firmware reads to tell variants apart.
   // Bus accesses are single words. Register contents sit in the low byte and the upper
   // bits of every read word are zero. Addresses that decode to nothing answer with a
   // slave error, so a host that probes the wrong offset hears about it at once.

   // Reset synchroniser and its released copy.
   logic                rst_meta_q;
   logic                rst_n_q;

   // Status capture.
   logic [REG_W-1:0]    status_q;
   logic [REG_W-1:0]    status_d;
   logic                prior_tsd_q;
   logic                prior_tsd_d;

   // Write path state.
   logic                awready_q;
   logic                wready_q;
   logic                aw_held_q;
   logic                w_held_q;
   logic [ADDR_W-1:0]   waddr_q;
   logic [DATA_W-1:0]   wdata_q;
   logic [STRB_W-1:0]   wstrb_q;
   logic                bvalid_q;
   logic [1:0]          bresp_q;

   // Read path state.
   logic                arready_q;
   logic                rvalid_q;
   logic [DATA_W-1:0]   rdata_q;
   logic [1:0]          rresp_q;

   // Decode wires.
   wire                 aw_take;
   wire                 w_take;
   wire                 aw_have;
   wire                 w_have;
   wire                 write_fire;
   wire                 b_done;
   wire                 ar_take;
   wire                 r_done;
   wire [ADDR_W-1:0]    cur_waddr;
   wire [DATA_W-1:0]    cur_wdata;
   wire [STRB_W-1:0]    cur_wstrb;
   wire                 wr_hit_status;
   wire                 wr_hit_version;
   wire                 wr_hit_control;
   wire                 wr_mapped;
   wire                 clear_tsd;
   wire                 rd_hit_status;
   wire                 rd_hit_version;
   wire                 rd_hit_control;
   wire                 rd_mapped;
   wire [REG_W-1:0]     version_word;
   wire [DATA_W-1:0]    rd_word;

   // The asynchronous reset is asserted at once and released two edges later.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   // Handshake notes.
   // A channel moves one item at the edge where its valid and its ready are both high.
   // The write address and write data may come in either order or together; each is
   // parked in a holding register until the other arrives, and only then is the write
   // carried out and the response raised. While a response waits, both write readies stay
   // low so that a second write cannot overtake the first. The read side is simpler: one
   // address is taken, the answer follows one edge later, and the address ready returns
   // only once the answer has been taken. No channel ever waits on a ready before it
   // raises its own valid, which keeps the slave free of combinational loops.

   // Handshake events on each channel.
   assign aw_take = s_axi_awvalid & awready_q;
   assign w_take  = s_axi_wvalid & wready_q;
   assign aw_have = aw_held_q | aw_take;
   assign w_have  = w_held_q | w_take;
   assign write_fire = aw_have & w_have & ~bvalid_q;
   assign b_done  = bvalid_q & s_axi_bready;
   assign ar_take = s_axi_arvalid & arready_q;
   assign r_done  = rvalid_q & s_axi_rready;

   // A write completes with whichever of address and data arrives last.
   assign cur_waddr = aw_held_q ? waddr_q : s_axi_awaddr;
   assign cur_wdata = w_held_q ? wdata_q : s_axi_wdata;
   assign cur_wstrb = w_held_q ? wstrb_q : s_axi_wstrb;

   // Write decode notes.
   // A write to either read-only register completes with an okay response so that host
   // drivers which write back a whole image of the map do not see spurious errors, but
   // no flip-flop of either register has a write path, so nothing can change.
   // Only the low byte lane of the control word matters; a write with that strobe clear
   // is answered but has no effect. The decode uses the held copy of address and data
   // when one of them arrived earlier than the other.

   // Write decode; the two read-only registers accept a write but keep their contents.
   assign wr_hit_status  = (cur_waddr == MON_STATUS_ADDR);
   assign wr_hit_version = (cur_waddr == SI_VERSION_ADDR);
   assign wr_hit_control = (cur_waddr == MON_CONTROL_ADDR);
   assign wr_mapped = wr_hit_status | wr_hit_version | wr_hit_control;
   assign clear_tsd = write_fire & wr_hit_control & cur_wstrb[0] & cur_wdata[CLEAR_TSD_BIT];

   // The shutdown memory is set by the event and cleared by software; a set wins.
   assign prior_tsd_d = thermal_shutdown_event | (prior_tsd_q & ~clear_tsd);

   // Status word notes.
   // The order of the fields is fixed: regulator in bit six down to the remembered
   // shutdown in bit zero. The top bit is reserved and is tied low so that a host can
   // mask the word safely against future use. The flag bit reaches the word one stage
   // after the flag itself, so a shutdown pulse shows two edges after the event.
   // A clear and a new event in the same cycle leave the flag set, so an event that
   // lands during the clear write is never lost.

   // Status word in fixed order with the top bit held at zero.
   always_comb begin
      status_d                  = MON_STATUS_RESET;
      status_d[RESERVED_BIT]    = 1'b0;
      status_d[AUX_REG_BIT]     = aux_regulator_ok;
      status_d[SECOND_CONV_BIT] = second_converter_ok;
      status_d[NET_SUPPLY_BIT]  = network_supply_ok;
      status_d[FILT_SUPPLY_BIT] = filtered_supply_ok;
      status_d[OSC_RUN_BIT]     = oscillator_running;
      status_d[THERM_WARN_BIT]  = thermal_warning;
      status_d[PRIOR_TSD_BIT]   = prior_tsd_q;
   end

   // Status capture, cleared to zero by reset.
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         status_q    <= MON_STATUS_RESET;
         prior_tsd_q <= 1'b0;
      end else begin
         status_q    <= status_d;
         prior_tsd_q <= prior_tsd_d;
      end
   end

   // Version word: revision above the part code, both fixed in silicon.
   assign version_word = {REVISION_CODE, PART_ID_CODE};

   // Read decode at the aligned word addresses.
   assign rd_hit_status  = (s_axi_araddr == MON_STATUS_ADDR);
   assign rd_hit_version = (s_axi_araddr == SI_VERSION_ADDR);
   assign rd_hit_control = (s_axi_araddr == MON_CONTROL_ADDR);
   assign rd_mapped = rd_hit_status | rd_hit_version | rd_hit_control;

   // Read data selection; narrow registers sit in the low bits.
   assign rd_word = rd_hit_status  ? {{(DATA_W-REG_W){1'b0}}, status_q} :
                    rd_hit_version ? {{(DATA_W-REG_W){1'b0}}, version_word} :
                    RDATA_RESET;

   // Write address capture.
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         awready_q <= 1'b0;
         aw_held_q <= 1'b0;
         waddr_q   <= '0;
      end else begin
         if (aw_take) begin
            waddr_q <= s_axi_awaddr;
         end
         if (write_fire) begin
            aw_held_q <= 1'b0;
         end else if (aw_take) begin
            aw_held_q <= 1'b1;
         end
         if (aw_take | write_fire) begin
            awready_q <= 1'b0;
         end else if (~aw_held_q & ~bvalid_q) begin
            awready_q <= 1'b1;
         end
      end
   end

   // Write data capture.
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         wready_q <= 1'b0;
         w_held_q <= 1'b0;
         wdata_q  <= '0;
         wstrb_q  <= '0;
      end else begin
         if (w_take) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (write_fire) begin
            w_held_q <= 1'b0;
         end else if (w_take) begin
            w_held_q <= 1'b1;
         end
         if (w_take | write_fire) begin
            wready_q <= 1'b0;
         end else if (~w_held_q & ~bvalid_q) begin
            wready_q <= 1'b1;
         end
      end
   end

   // Write response notes.
   // The response is raised at the same edge as the later of the two handshakes and
   // stands, with its code, until the master takes it. The readies of the address and
   // data channels come back one edge after the response is taken, which bounds the
   // write rate at one word in three cycles; that is ample for status polling.

   // Write response; unmapped addresses answer with a slave error.
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end else begin
         if (write_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
         end else if (b_done) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // Read channel notes.
   // The read word is captured at the address handshake, so it is a snapshot of the
   // registered status at that edge; a monitor that changes while the answer waits for
   // the master does not disturb the data already on the bus. The address ready stays
   // low while an answer stands, which keeps at most one read under way, and comes back
   // at the edge where the answer is taken. Unmapped addresses, including misaligned
   // ones, return zero data with a slave error. The control word has no read path and
   // returns zero with an okay response.

   // Read channel: one read at a time, data one edge after the address.
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rdata_q   <= RDATA_RESET;
         rresp_q   <= RESP_OKAY;
      end else begin
         if (ar_take) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= rd_word;
            rresp_q   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
         end else if (r_done) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
         end else if (~rvalid_q) begin
            arready_q <= 1'b1;
         end
      end
   end

   // Output notes.
   // Every bus output is the plain output of a flip-flop, with no gate after it, so the
   // timing seen by the master is one clock-to-output delay and no glitch can reach the
   // interconnect. The protection inputs of both address channels are accepted but not
   // used, since the bank holds nothing that needs privileged or secure access.

   // Outputs straight from flip-flops.
   assign s_axi_awready = awready_q;
   assign s_axi_wready  = wready_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

endmodule : monitor_status_regs

/* File: verification/monitor_status_assertions.sv */
// Checker of the bus behaviour of the monitor status bank.
`timescale 1ns/1ps
module monitor_status_checker #(
   parameter logic [monitor_status_pkg::REVISION_W-1:0] REVISION_CODE = 3'h0,
   parameter logic [monitor_status_pkg::PART_ID_W-1:0]  PART_ID_CODE  = 5'h12
) (
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   import monitor_status_pkg::*;
   logic [7:0] ar_q;
   logic [7:0] aw_q;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Remembers the addresses of the accesses under way.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ar_q <= 8'h00;
         aw_q <= 8'h00;
      end else begin
         if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
         if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
      end
   end
   AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("Read answer missing one cycle after address.");
   AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("Read answer changed before it was taken.");
   AST_RD_DONE: assert property (s_axi_rvalid && s_axi_rready |=>
      !s_axi_rvalid ##[0:1] s_axi_arready)
      else $error("Read channel did not return to idle.");
   AST_AR_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("Address accepted during a pending read.");
   AST_UPPER_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("Upper read data bits not zero.");
   AST_STATUS_RSV: assert property (s_axi_rvalid && ar_q == MON_STATUS_ADDR |->
      !s_axi_rdata[7] && s_axi_rresp == RESP_OKAY)
      else $error("Status read shows reserved bit or error.");
   AST_VERSION: assert property (s_axi_rvalid && ar_q == SI_VERSION_ADDR |->
      s_axi_rdata[7:0] == {REVISION_CODE, PART_ID_CODE} && s_axi_rresp == RESP_OKAY)
      else $error("Version register read wrong.");
   AST_RO_WRITE: assert property (s_axi_bvalid && (aw_q == MON_STATUS_ADDR ||
      aw_q == SI_VERSION_ADDR) |-> s_axi_bresp == RESP_OKAY)
      else $error("Write to read-only register not answered okay.");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp) && !s_axi_awready && !s_axi_wready)
      else $error("Write response dropped or new write accepted.");
endmodule : monitor_status_checker

bind monitor_status_regs monitor_status_checker #(
   .REVISION_CODE(REVISION_CODE), .PART_ID_CODE(PART_ID_CODE)) monitor_status_checker_i (
   .clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

/* File: verification/host_master.sv */
// Host controller model that reads and writes the bank over AXI4-Lite.
`timescale 1ns/1ps
module host_master (
   input  wire logic        clk,
   output logic [7:0]       s_axi_awaddr,
   output logic             s_axi_awvalid,
   input  wire logic        s_axi_awready,
   output logic [31:0]      s_axi_wdata,
   output logic [3:0]       s_axi_wstrb,
   output logic             s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   output logic             s_axi_bready,
   output logic [7:0]       s_axi_araddr,
   output logic             s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic [1:0]  s_axi_rresp,
   input  wire logic        s_axi_rvalid,
   output logic             s_axi_rready
);
   // The bus starts idle.
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= 52'h0;
   end
   // Writes one word; each channel is released once it is taken.
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
      s_axi_awaddr <= ~a;
      s_axi_wdata <= ~v;
      s_axi_bready <= 1'b1;
      do @(posedge clk); while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   // Reads one word and returns data and response.
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      s_axi_araddr <= ~a;
      s_axi_rready <= 1'b1;
      do @(posedge clk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
endmodule : host_master

/* File: verification/monitor_status_regs_tb_top.sv */
// Testbench of the monitor status bank.
`timescale 1ns/1ps
module monitor_status_regs_tb_top;
   import monitor_status_pkg::*;
   localparam logic [2:0]  REV = 3'h5;  // Arbitrary revision for this run.
   localparam logic [4:0]  PID = 5'h0a; // Arbitrary part code for this run.
   localparam logic [31:0] VER = {24'h0, REV, PID};
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic [6:1]  lvl = 6'h00;
   logic        prior_thermal_shutdown = 1'b0;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   int          n_errors = 0;
   int          compares = 0;
   int          cyc = 0;
   always #5 clk = ~clk;
   monitor_status_regs #(.REVISION_CODE(REV), .PART_ID_CODE(PID)) monitor_status_regs_i (
      .clk, .reset_n, .aux_regulator_ok(lvl[6]), .second_converter_ok(lvl[5]),
      .network_supply_ok(lvl[4]), .filtered_supply_ok(lvl[3]), .oscillator_running(lvl[2]),
      .thermal_warning(lvl[1]), .thermal_shutdown_event(prior_thermal_shutdown), .s_axi_awaddr,
      .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   host_master host_master_i (.clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   // Prints the verdict and ends the run.
   task results;
      if (n_errors == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : results
   // Compares a response code and data word with the expectation.
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      compares++;
      if (got !== exp) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         n_errors++;
      end
   endtask : chk
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      host_master_i.rd(a, d, r);
      chk({r, d}, {er, e});
   endtask : rchk
   task automatic wchk(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
      host_master_i.wr(a, v, r);
      chk({32'h0, r}, {32'h0, er});
   endtask : wchk
   // Cuts a hung run short.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         results();
      end
   end
   // Main sequence of accesses and monitor changes.
   initial begin
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      rchk(SI_VERSION_ADDR, VER, RESP_OKAY);
      rchk(MON_STATUS_ADDR, 32'h0, RESP_OKAY);
      for (int i = 1; i < 8; i++) begin
         @(posedge clk);
         lvl <= (i == 7) ? 6'h3f : 6'(1 << (i - 1));
         repeat (3) @(posedge clk);
         rchk(MON_STATUS_ADDR, (i == 7) ? 32'h7e : 32'(1 << i), RESP_OKAY);
      end
      @(posedge clk);
      prior_thermal_shutdown <= 1'b1;
      @(posedge clk);
      prior_thermal_shutdown <= 1'b0;
      repeat (3) @(posedge clk);
      rchk(MON_STATUS_ADDR, 32'h7f, RESP_OKAY);
      wchk(MON_STATUS_ADDR, 32'hff, RESP_OKAY);
      wchk(SI_VERSION_ADDR, 32'h00, RESP_OKAY);
      rchk(MON_STATUS_ADDR, 32'h7f, RESP_OKAY);
      rchk(SI_VERSION_ADDR, VER, RESP_OKAY);
      wchk(MON_CONTROL_ADDR, 32'h1, RESP_OKAY);
      repeat (3) @(posedge clk);
      rchk(MON_STATUS_ADDR, 32'h7e, RESP_OKAY);
      wchk(8'h40, 32'h1, RESP_SLVERR);
      rchk(8'h0d, 32'h0, RESP_SLVERR);
      results();
   end
endmodule : monitor_status_regs_tb_top
